// ==== rtl/data_space_access.sv ====
// Data space access: X read/write and Y read paths with checks
`timescale 1ns/1ns
`default_nettype none
`include "data_space_regs.svh"

module data_space_access (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // X read request
    input wire data_space_pkg::x_read_req_t x_rd_in,
    // Y read request, word only
    input wire data_space_pkg::y_read_req_t y_rd_in,
    // X write request
    input wire data_space_pkg::x_write_req_t x_wr_in,
    // Pointer post-modification request
    input wire data_space_pkg::agu_req_t agu_in,
    // X read answer
    output logic [`DS_WORD_W-1:0] x_rd_data_out,
    output logic x_rd_valid_out,
    output logic [`DS_WORD_W-1:0] wreg_load_out,
    // Y read answer
    output logic [`DS_WORD_W-1:0] y_rd_data_out,
    output logic y_rd_valid_out,
    // Write acknowledge
    output logic x_wr_done_out,
    // Address error trap request
    output logic addr_err_out,
    // Modified pointer
    output logic [`DS_EA_W-1:0] ptr_out,
    output logic ptr_valid_out
);
    import data_space_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Address decode helpers

    // Boundary is a compile-time constant: nothing can move it
    function automatic logic in_y(input logic [`DS_EA_W-1:0] a);
        return (a >= `DS_Y_BASE) && (a <= `DS_Y_TOP);
    endfunction

    function automatic logic in_phys(input logic [`DS_EA_W-1:0] a);
        return a <= `DS_PHYS_TOP;
    endfunction

    function automatic logic [`DS_EA_W-1:0] resolve_ea(
        input ea_src_t s, input logic [`DS_EA_W-1:0] a);
        logic [`DS_EA_W-1:0] r;
        r = a;
        case (s)
            SRC_NEAR: begin
                r = {{(`DS_EA_W-`DS_NEAR_W){1'b0}},
                     a[`DS_NEAR_W-1:0]};
            end
            SRC_ABS: begin
                r = a;
            end
            SRC_IND: begin
                r = a;
            end
            default: begin
                r = a;
            end
        endcase
        return r;
    endfunction

    function automatic logic [`DS_IDX_W-1:0] word_idx(
        input logic [`DS_EA_W-1:0] a);
        return a[`DS_IDX_W:1];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Storage: two byte-wide halves with one word decode

    logic [`DS_BYTE_W-1:0] mem_lo [`DS_MEM_WORDS];
    logic [`DS_BYTE_W-1:0] mem_hi [`DS_MEM_WORDS];

    ////////////////////////////////////////////////////////////////////
    // X read path

    wire logic [`DS_EA_W-1:0] xr_ea = resolve_ea(x_rd_in.src, x_rd_in.ea);
    // MAC data reads see X without the Y block; all others see it all
    wire logic xr_own = x_rd_in.mac ? !in_y(xr_ea) : 1'b1;
    wire logic xr_ok = in_phys(xr_ea) && xr_own;
    wire logic xr_misalign = x_rd_in.valid && !x_rd_in.byte_op &&
        xr_ea[0];
    wire logic [`DS_IDX_W-1:0] xr_idx = word_idx(xr_ea);
    wire logic [`DS_BYTE_W-1:0] xr_lo_byte = mem_lo[xr_idx];
    wire logic [`DS_BYTE_W-1:0] xr_hi_byte = mem_hi[xr_idx];
    wire logic [`DS_BYTE_W-1:0] xr_sel_byte =
        xr_ea[0] ? xr_hi_byte : xr_lo_byte;
    wire logic [`DS_BYTE_W-1:0] xr_byte =
        xr_ok ? xr_sel_byte : `DS_ZERO_BYTE;
    // A misaligned word read still completes on the containing word
    wire logic [`DS_WORD_W-1:0] xr_word =
        xr_ok ? {xr_hi_byte, xr_lo_byte} : `DS_ZERO_WORD;
    wire logic [`DS_WORD_W-1:0] xr_data_next = x_rd_in.byte_op ?
        {`DS_ZERO_BYTE, xr_byte} : xr_word;
    wire logic [`DS_WORD_W-1:0] wreg_next = x_rd_in.byte_op ?
        {x_rd_in.dest_hi, xr_byte} : xr_word;

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            x_rd_valid_out <= 1'b0;
            x_rd_data_out <= `DS_ZERO_WORD;
            wreg_load_out <= `DS_ZERO_WORD;
        end else begin
            x_rd_valid_out <= x_rd_in.valid;
            if (x_rd_in.valid) begin
                x_rd_data_out <= xr_data_next;
                wreg_load_out <= wreg_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Y read path: word fetch only, no write port exists on it

    wire logic yr_ok = in_y(y_rd_in.ea) && in_phys(y_rd_in.ea);
    // Bit 0 is dropped: the Y path cannot deliver a byte
    wire logic [`DS_IDX_W-1:0] yr_idx = word_idx(y_rd_in.ea);
    wire logic [`DS_WORD_W-1:0] yr_data_next = yr_ok ?
        {mem_hi[yr_idx], mem_lo[yr_idx]} : `DS_ZERO_WORD;

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            y_rd_valid_out <= 1'b0;
            y_rd_data_out <= `DS_ZERO_WORD;
        end else begin
            y_rd_valid_out <= y_rd_in.valid;
            if (y_rd_in.valid) begin
                y_rd_data_out <= yr_data_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // X write path: the only path that changes memory

    // Write-back of accumulators uses the combined space, like non-MAC
    wire logic [`DS_EA_W-1:0] xw_ea =
        resolve_ea(x_wr_in.src, x_wr_in.ea);
    wire logic xw_misalign = x_wr_in.valid && !x_wr_in.byte_op &&
        xw_ea[0];
    // Misalignment is decoded combinationally so the strobe never fires
    wire logic xw_go = x_wr_in.valid && in_phys(xw_ea) &&
        !xw_misalign;
    wire logic we_lo = xw_go &&
        (!x_wr_in.byte_op || !xw_ea[0]);
    wire logic we_hi = xw_go &&
        (!x_wr_in.byte_op || xw_ea[0]);
    wire logic [`DS_IDX_W-1:0] xw_idx = word_idx(xw_ea);
    wire logic [`DS_BYTE_W-1:0] wd_lo = x_wr_in.data[`DS_BYTE_W-1:0];
    // A byte write carries its byte in the low lane of the data
    wire logic [`DS_BYTE_W-1:0] wd_hi = x_wr_in.byte_op ?
        x_wr_in.data[`DS_BYTE_W-1:0] :
        x_wr_in.data[`DS_WORD_W-1:`DS_BYTE_W];

    always_ff @(posedge core_clk_in) begin
        if (we_lo) begin
            mem_lo[xw_idx] <= wd_lo;
        end
        if (we_hi) begin
            mem_hi[xw_idx] <= wd_hi;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            x_wr_done_out <= 1'b0;
        end else begin
            x_wr_done_out <= x_wr_in.valid;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address error trap: raised after the access has been dealt with

    wire logic err_next = xr_misalign || xw_misalign;

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            addr_err_out <= 1'b0;
        end else begin
            addr_err_out <= err_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pointer post-modification

    pointer_step step_u (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .req_in(agu_in),
        .ptr_out(ptr_out),
        .ptr_valid_out(ptr_valid_out)
    );

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    // Stored words before any zeroing, for the data checks below
    wire logic [`DS_WORD_W-1:0] xr_raw_word = {xr_hi_byte, xr_lo_byte};
    wire logic [`DS_WORD_W-1:0] yr_raw_word =
        {mem_hi[yr_idx], mem_lo[yr_idx]};

    x_mac_zero_a: assert property (
        x_rd_in.valid && x_rd_in.mac && in_y(xr_ea) |=>
        x_rd_data_out == `DS_ZERO_WORD && wreg_load_out[7:0] == 8'h00)
        else $error("MAC X read into Y space not zero");
    y_foreign_zero_a: assert property (
        y_rd_in.valid && !in_y(y_rd_in.ea) |=>
        y_rd_valid_out && y_rd_data_out == `DS_ZERO_WORD)
        else $error("Y read outside Y space not zero");
    unimpl_zero_a: assert property (
        x_rd_in.valid && !in_phys(xr_ea) |=>
        x_rd_data_out == `DS_ZERO_WORD)
        else $error("unimplemented address not zero");
    misalign_trap_a: assert property (
        (x_rd_in.valid && !x_rd_in.byte_op && xr_ea[0]) ||
        (x_wr_in.valid && !x_wr_in.byte_op && xw_ea[0]) |=>
        addr_err_out)
        else $error("misaligned word access without trap");
    aligned_quiet_a: assert property (
        !(x_rd_in.valid && !x_rd_in.byte_op && xr_ea[0]) &&
        !(x_wr_in.valid && !x_wr_in.byte_op && xw_ea[0]) |=>
        !addr_err_out)
        else $error("trap without misaligned access");
    write_suppress_a: assert property (
        x_wr_in.valid && !x_wr_in.byte_op && xw_ea[0] |->
        !we_lo && !we_hi)
        else $error("misaligned write reached memory");
    byte_lane_a: assert property (
        x_wr_in.valid && x_wr_in.byte_op && in_phys(xw_ea) |->
        (we_hi == xw_ea[0]) && (we_lo == !xw_ea[0]))
        else $error("byte write strobed the wrong lane");
    byte_read_lane_a: assert property (
        x_rd_in.valid && x_rd_in.byte_op |=>
        x_rd_data_out[15:8] == 8'h00)
        else $error("byte read not on low lane");
    wreg_merge_a: assert property (
        x_rd_in.valid && x_rd_in.byte_op |=>
        wreg_load_out[15:8] == $past(x_rd_in.dest_hi) &&
        wreg_load_out[7:0] == x_rd_data_out[7:0])
        else $error("byte load changed register upper byte");
    near_field_a: assert property (
        x_rd_in.valid && x_rd_in.src == SRC_NEAR |->
        xr_ea == {3'h0, x_rd_in.ea[12:0]})
        else $error("near address left the near region");
    rd_pulse_a: assert property (
        x_rd_in.valid |=> x_rd_valid_out)
        else $error("X read answer missing");
    rd_idle_a: assert property (
        !x_rd_in.valid |=> !x_rd_valid_out)
        else $error("X read answer without request");
    rd_hold_a: assert property (
        !x_rd_in.valid |=> $stable(x_rd_data_out))
        else $error("X read data changed without request");
    y_pulse_a: assert property (
        y_rd_in.valid |=> y_rd_valid_out)
        else $error("Y read answer missing");
    y_idle_a: assert property (
        !y_rd_in.valid |=> !y_rd_valid_out)
        else $error("Y read answer without request");
    y_hold_a: assert property (
        !y_rd_in.valid |=> $stable(y_rd_data_out))
        else $error("Y read data changed without request");
    wr_done_a: assert property (
        x_wr_in.valid |=> x_wr_done_out)
        else $error("X write not acknowledged");
    wr_quiet_a: assert property (
        !x_wr_in.valid |=> !x_wr_done_out)
        else $error("X write acknowledged without request");
    wr_idle_a: assert property (
        !x_wr_in.valid |-> !we_lo && !we_hi)
        else $error("memory strobed without a write request");
    wr_range_a: assert property (
        x_wr_in.valid && !in_phys(xw_ea) |-> !we_lo && !we_hi)
        else $error("write outside memory reached storage");
    word_lanes_a: assert property (
        x_wr_in.valid && !x_wr_in.byte_op && !xw_ea[0] &&
        in_phys(xw_ea) |-> we_lo && we_hi)
        else $error("aligned word write missed a lane");
    acc_wb_a: assert property (
        x_wr_in.valid && x_wr_in.acc_wb && !x_wr_in.byte_op &&
        !xw_ea[0] && in_phys(xw_ea) |-> we_lo && we_hi)
        else $error("accumulator write-back not stored");
    linear_read_a: assert property (
        x_rd_in.valid && !x_rd_in.mac && !x_rd_in.byte_op &&
        in_phys(xr_ea) |=> x_rd_data_out == $past(xr_raw_word))
        else $error("combined space word read lost data");
    mac_x_read_a: assert property (
        x_rd_in.valid && x_rd_in.mac && !x_rd_in.byte_op &&
        in_phys(xr_ea) && !in_y(xr_ea) |=>
        x_rd_data_out == $past(xr_raw_word))
        else $error("MAC X read outside Y lost data");
    misalign_done_a: assert property (
        x_rd_in.valid && !x_rd_in.byte_op && xr_ea[0] && xr_ok |=>
        x_rd_valid_out && x_rd_data_out == $past(xr_raw_word))
        else $error("misaligned read did not complete");
    y_word_a: assert property (
        y_rd_in.valid && in_y(y_rd_in.ea) |=>
        y_rd_data_out == $past(yr_raw_word))
        else $error("Y read inside Y space lost data");
    wreg_word_a: assert property (
        x_rd_in.valid && !x_rd_in.byte_op |=>
        wreg_load_out == x_rd_data_out)
        else $error("word load differs from read data");

    ////////////////////////////////////////////////////////////////////
    // Cover points

    concurrent_c: cover property (x_rd_in.valid && x_rd_in.mac &&
        y_rd_in.valid && yr_ok && xr_ok);
    nonmac_y_c: cover property (x_rd_in.valid && !x_rd_in.mac &&
        in_y(xr_ea));
    misalign_wr_c: cover property (x_wr_in.valid && xw_misalign);
    acc_wb_y_c: cover property (x_wr_in.valid && x_wr_in.acc_wb &&
        in_y(xw_ea));

endmodule
`default_nettype wire

// ==== rtl/data_space_regs.svh ====
// Address map, widths and step constants of the data space access block
`ifndef DATA_SPACE_REGS_SVH
`define DATA_SPACE_REGS_SVH

`define DS_EA_W 16
`define DS_WORD_W 16
`define DS_BYTE_W 8
`define DS_NEAR_W 13
`define DS_IDX_W 11
`define DS_MEM_WORDS 2048
`define DS_PHYS_TOP 16'h0fff
`define DS_Y_BASE 16'h0c00
`define DS_Y_TOP 16'h0fff
`define DS_STEP_BYTE 16'h0001
`define DS_STEP_WORD 16'h0002
`define DS_ZERO_WORD 16'h0000
`define DS_ZERO_BYTE 8'h00

`endif

// ==== rtl/data_space_pkg.sv ====
// Types shared by the data space access block and its pointer unit
`include "data_space_regs.svh"

package data_space_pkg;

    // Where an X side address comes from
    typedef enum logic [2:0] {
        SRC_IND = 3'h1,
        SRC_NEAR = 3'h2,
        SRC_ABS = 3'h4
    } ea_src_t;

    typedef struct packed {
        logic valid;
        logic byte_op;
        logic mac;
        ea_src_t src;
        logic [`DS_EA_W-1:0] ea;
        logic [`DS_BYTE_W-1:0] dest_hi;
    } x_read_req_t;

    typedef struct packed {
        logic valid;
        logic [`DS_EA_W-1:0] ea;
    } y_read_req_t;

    typedef struct packed {
        logic valid;
        logic byte_op;
        logic acc_wb;
        ea_src_t src;
        logic [`DS_EA_W-1:0] ea;
        logic [`DS_WORD_W-1:0] data;
    } x_write_req_t;

    typedef struct packed {
        logic valid;
        logic byte_op;
        logic decrement;
        logic modulo;
        logic bit_rev;
        logic is_write;
        logic [`DS_EA_W-1:0] ptr;
        logic [`DS_EA_W-1:0] mod_start;
        logic [`DS_EA_W-1:0] mod_end;
        logic [`DS_EA_W-1:0] rev_step;
    } agu_req_t;

endpackage

// ==== rtl/pointer_step.sv ====
// Pointer post-modification: size scaled, modulo and (for write pointers only) bit-reversed stepping
`timescale 1ns/1ns
`default_nettype none
`include "data_space_regs.svh"

module pointer_step (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Request
    input wire data_space_pkg::agu_req_t req_in,
    // Result
    output logic [`DS_EA_W-1:0] ptr_out,
    output logic ptr_valid_out
);
    import data_space_pkg::*;

    function automatic logic [`DS_EA_W-1:0] rev16(
        input logic [`DS_EA_W-1:0] v);
        logic [`DS_EA_W-1:0] r;
        r = `DS_ZERO_WORD;
        for (int i = 0; i < `DS_EA_W; i++) begin
            r[i] = v[`DS_EA_W-1-i];
        end
        return r;
    endfunction

    wire logic [`DS_EA_W-1:0] step =
        req_in.byte_op ? `DS_STEP_BYTE : `DS_STEP_WORD;
    wire logic [`DS_EA_W-1:0] lin_ptr = req_in.decrement ?
        req_in.ptr - step : req_in.ptr + step;
    // Reversed addressing only ever applies to write pointers
    wire logic use_rev = req_in.bit_rev & req_in.is_write;
    wire logic [`DS_EA_W-1:0] rev_ptr =
        rev16(rev16(req_in.ptr) + rev16(req_in.rev_step));
    wire logic wrap_up = req_in.modulo & !req_in.decrement &
        (req_in.ptr >= req_in.mod_end);
    wire logic wrap_dn = req_in.modulo & req_in.decrement &
        (req_in.ptr <= req_in.mod_start);
    wire logic [`DS_EA_W-1:0] ptr_next =
        use_rev ? rev_ptr :
        wrap_up ? req_in.mod_start :
        wrap_dn ? req_in.mod_end : lin_ptr;

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            ptr_out <= `DS_ZERO_WORD;
            ptr_valid_out <= 1'b0;
        end else begin
            ptr_valid_out <= req_in.valid;
            if (req_in.valid) begin
                ptr_out <= ptr_next;
            end
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    step_scale_a: assert property (
        req_in.valid && !req_in.modulo && !req_in.bit_rev &&
        !req_in.decrement |=>
        ptr_out == $past(req_in.ptr) +
            ($past(req_in.byte_op) ? `DS_STEP_BYTE : `DS_STEP_WORD))
        else $error("pointer step not scaled to size");
    rev_read_off_a: assert property (
        req_in.valid && req_in.bit_rev && !req_in.is_write &&
        !req_in.modulo && req_in.decrement |=>
        ptr_out == $past(req_in.ptr) -
            ($past(req_in.byte_op) ? `DS_STEP_BYTE : `DS_STEP_WORD))
        else $error("reversed step used on a read pointer");
    modulo_wrap_a: assert property (
        req_in.valid && req_in.modulo && !req_in.bit_rev &&
        !req_in.decrement && req_in.ptr >= req_in.mod_end |=>
        ptr_out == $past(req_in.mod_start))
        else $error("modulo buffer did not wrap");
    rev_cov_c: cover property (req_in.valid && use_rev);

endmodule
`default_nettype wire

// ==== verification/core_agu_model.sv ====
// Core side model: address generation units issuing data space requests
`timescale 1ns/1ns
`default_nettype none

module core_agu_model (
    // Clock
    input wire logic core_clk_in,
    // Requests towards the data space block
    output var data_space_pkg::x_read_req_t x_rd_out,
    output var data_space_pkg::y_read_req_t y_rd_out,
    output var data_space_pkg::x_write_req_t x_wr_out,
    output var data_space_pkg::agu_req_t agu_out
);
    import data_space_pkg::*;

    x_read_req_t x_rd_nx;
    y_read_req_t y_rd_nx;
    x_write_req_t x_wr_nx;
    agu_req_t agu_nx;

    initial begin
        x_rd_out = '0;
        y_rd_out = '0;
        x_wr_out = '0;
        agu_out = '0;
        x_rd_nx = '0;
        y_rd_nx = '0;
        x_wr_nx = '0;
        agu_nx = '0;
    end

    task automatic x_read(input logic b, input logic m, input ea_src_t s,
                          input logic [15:0] a, input logic [7:0] hi);
        x_rd_nx = '{valid:1'b1, byte_op:b, mac:m, src:s, ea:a, dest_hi:hi};
    endtask

    // Word only: the Y request carries no size flag at all
    task automatic y_read(input logic [15:0] a);
        y_rd_nx = '{valid:1'b1, ea:a};
    endtask

    task automatic x_write(input logic b, input logic acc, input ea_src_t s,
                           input logic [15:0] a, input logic [15:0] d);
        x_wr_nx = '{valid:1'b1, byte_op:b, acc_wb:acc, src:s, ea:a, data:d};
    endtask

    task automatic step(input logic b, input logic dec, input logic md,
                        input logic rv, input logic wr, input logic [15:0] p);
        agu_nx = '{valid:1'b1, byte_op:b, decrement:dec, modulo:md,
                    bit_rev:rv, is_write:wr, ptr:p, mod_start:16'h0200,
                    mod_end:16'h0210, rev_step:16'h0008};
    endtask

    // Each bus is driven once per falling edge: what was posted, or idle
    // with released fields showing the inverse of their last value
    task automatic cycle();
        x_rd_out = x_rd_nx;
        y_rd_out = y_rd_nx;
        x_wr_out = x_wr_nx;
        agu_out = agu_nx;
        x_rd_nx.valid = 1'b0;
        x_rd_nx.ea = ~x_rd_nx.ea;
        y_rd_nx.valid = 1'b0;
        y_rd_nx.ea = ~y_rd_nx.ea;
        x_wr_nx.valid = 1'b0;
        x_wr_nx.data = ~x_wr_nx.data;
        agu_nx.valid = 1'b0;
        agu_nx.ptr = ~agu_nx.ptr;
        @(posedge core_clk_in);
        @(negedge core_clk_in);
    endtask
endmodule

`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the data space access block
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import data_space_pkg::*;

    logic core_clk_in;
    logic rst_b_in;
    x_read_req_t x_rd;
    y_read_req_t y_rd;
    x_write_req_t x_wr;
    agu_req_t agu;
    logic [15:0] x_rd_data;
    logic [15:0] wreg_load;
    logic [15:0] y_rd_data;
    logic [15:0] ptr;
    logic x_rd_valid;
    logic y_rd_valid;
    logic x_wr_done;
    logic addr_err;
    logic ptr_valid;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    core_agu_model core (.core_clk_in(core_clk_in), .x_rd_out(x_rd),
        .y_rd_out(y_rd), .x_wr_out(x_wr), .agu_out(agu));

    data_space_access uut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .x_rd_in(x_rd), .y_rd_in(y_rd), .x_wr_in(x_wr), .agu_in(agu),
        .x_rd_data_out(x_rd_data), .x_rd_valid_out(x_rd_valid),
        .wreg_load_out(wreg_load), .y_rd_data_out(y_rd_data),
        .y_rd_valid_out(y_rd_valid), .x_wr_done_out(x_wr_done),
        .addr_err_out(addr_err), .ptr_out(ptr), .ptr_valid_out(ptr_valid));

    initial core_clk_in = 1'b0;
    always #20 core_clk_in = ~core_clk_in;

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Whole run needs under fifty cycles; this only catches a hang
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles >= 3000) begin
            errors++;
            close_out();
        end
    end

    task automatic check_word(input string n, input logic [15:0] e,
                              input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_bit(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic b, input logic [15:0] a,
                      input logic [15:0] d);
        core.x_write(b, 1'b0, SRC_IND, a, d);
        core.cycle();
        check_bit("x_wr_done", 1'b1, x_wr_done);
    endtask

    task automatic expect_x(input logic [15:0] d, input logic [15:0] w,
                            input logic e);
        check_bit("x_rd_valid", 1'b1, x_rd_valid);
        check_word("x_rd_data", d, x_rd_data);
        check_word("wreg_load", w, wreg_load);
        check_bit("addr_err", e, addr_err);
    endtask

    task automatic rd(input logic b, input logic m, input logic [15:0] a,
                      input logic [7:0] hi, input logic [15:0] d,
                      input logic [15:0] w);
        core.x_read(b, m, SRC_IND, a, hi);
        core.cycle();
        expect_x(d, w, 1'b0);
    endtask

    task automatic t_word_rw();
        wr(1'b0, 16'h0100, 16'h1234);
        core.x_write(1'b0, 1'b0, SRC_IND, 16'h0100, 16'h5678);
        core.x_read(1'b0, 1'b0, SRC_IND, 16'h0100, 8'h00);
        core.cycle();
        expect_x(16'h1234, 16'h1234, 1'b0);
        rd(1'b0, 1'b0, 16'h0100, 8'h00, 16'h5678, 16'h5678);
    endtask

    task automatic t_bytes();
        wr(1'b0, 16'h0200, 16'h1234);
        wr(1'b1, 16'h0201, 16'h00ab);
        wr(1'b1, 16'h0200, 16'hffcd);
        rd(1'b0, 1'b0, 16'h0200, 8'h00, 16'habcd, 16'habcd);
        rd(1'b1, 1'b0, 16'h0201, 8'h5a, 16'h00ab, 16'h5aab);
        rd(1'b1, 1'b0, 16'h0200, 8'h11, 16'h00cd, 16'h11cd);
    endtask

    task automatic t_invalid();
        wr(1'b0, 16'h0000, 16'h1111);
        wr(1'b0, 16'h1000, 16'h2222);
        rd(1'b0, 1'b0, 16'h0000, 8'h00, 16'h1111, 16'h1111);
        rd(1'b0, 1'b0, 16'h1000, 8'h00, 16'h0000, 16'h0000);
        rd(1'b1, 1'b0, 16'hffff, 8'h00, 16'h0000, 16'h0000);
    endtask

    task automatic mac_pair(input logic [15:0] xa, input logic [15:0] ya,
                            input logic [15:0] xd, input logic [15:0] yd);
        core.x_read(1'b0, 1'b1, SRC_IND, xa, 8'h00);
        core.y_read(ya);
        core.cycle();
        expect_x(xd, xd, 1'b0);
        check_bit("y_rd_valid", 1'b1, y_rd_valid);
        check_word("y_rd_data", yd, y_rd_data);
    endtask

    task automatic t_mac();
        core.x_write(1'b0, 1'b1, SRC_IND, 16'h0c00, 16'h5555);
        core.cycle();
        check_bit("x_wr_done", 1'b1, x_wr_done);
        wr(1'b0, 16'h0100, 16'h6666);
        mac_pair(16'h0100, 16'h0c00, 16'h6666, 16'h5555);
        mac_pair(16'h0c00, 16'h0100, 16'h0000, 16'h0000);
        mac_pair(16'h0100, 16'h0c01, 16'h6666, 16'h5555);
        mac_pair(16'h0100, 16'h1000, 16'h6666, 16'h0000);
        rd(1'b0, 1'b0, 16'h0c00, 8'h00, 16'h5555, 16'h5555);
    endtask

    task automatic t_align();
        wr(1'b0, 16'h0300, 16'h7777);
        core.x_read(1'b0, 1'b0, SRC_IND, 16'h0301, 8'h00);
        core.cycle();
        expect_x(16'h7777, 16'h7777, 1'b1);
        wr(1'b0, 16'h0301, 16'h9999);
        check_bit("addr_err", 1'b1, addr_err);
        rd(1'b0, 1'b0, 16'h0300, 8'h00, 16'h7777, 16'h7777);
    endtask

    task automatic t_near();
        core.x_write(1'b0, 1'b0, SRC_NEAR, 16'he400, 16'h4444);
        core.cycle();
        core.x_read(1'b0, 1'b0, SRC_ABS, 16'h0400, 8'h00);
        core.cycle();
        expect_x(16'h4444, 16'h4444, 1'b0);
        core.x_read(1'b0, 1'b0, SRC_NEAR, 16'h2400, 8'h00);
        core.cycle();
        expect_x(16'h4444, 16'h4444, 1'b0);
    endtask

    task automatic st(input logic b, input logic dec, input logic md,
                      input logic rv, input logic w, input logic [15:0] p,
                      input logic [15:0] e);
        core.step(b, dec, md, rv, w, p);
        core.cycle();
        check_bit("ptr_valid", 1'b1, ptr_valid);
        check_word("ptr", e, ptr);
    endtask

    // Modulo window 0x0200..0x0210, reversed step 0x0008
    task automatic t_ptr();
        st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0100, 16'h0101);
        st(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0100, 16'h0102);
        st(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0100, 16'h00fe);
        st(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0100, 16'h00ff);
        st(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0210, 16'h0200);
        st(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0204, 16'h0206);
        st(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0200, 16'h0210);
        st(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0100, 16'h00fe);
        st(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0008, 16'h0004);
        st(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0004, 16'h000c);
    endtask

    // Reset in mid-run: outputs clear, requests ignored, memory kept
    task automatic t_reset();
        rst_b_in = 1'b0;
        core.step(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0100);
        core.cycle();
        check_bit("ptr_valid", 1'b0, ptr_valid);
        check_word("ptr", 16'h0000, ptr);
        check_word("x_rd_data", 16'h0000, x_rd_data);
        check_word("wreg_load", 16'h0000, wreg_load);
        rst_b_in = 1'b1;
        core.cycle();
        check_bit("x_rd_valid", 1'b0, x_rd_valid);
        rd(1'b0, 1'b0, 16'h0300, 8'h00, 16'h7777, 16'h7777);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b_in = 1'b0;
        repeat (2) @(posedge core_clk_in);
        @(negedge core_clk_in);
        rst_b_in = 1'b1;
        @(posedge core_clk_in);
        @(negedge core_clk_in);
        check_bit("x_rd_valid", 1'b0, x_rd_valid);
        check_bit("addr_err", 1'b0, addr_err);
        t_word_rw();
        t_bytes();
        t_invalid();
        t_mac();
        t_align();
        t_near();
        t_ptr();
        t_reset();
        close_out();
    end
endmodule

`default_nettype wire
